// ---- logic/tfe_pkg.sv ----
// Purpose: shared constants and carriers for the trace and format error exception unit
// Assumes: 32-bit logical addresses, 16-bit status word
// Notes: stack offsets are byte offsets from the stack pointer
package tfe_pkg;
  localparam int unsigned TFE_SR_W = 16;
  localparam int unsigned TFE_ADDR_W = 32;
  localparam int unsigned TFE_SR_TALL_POS = 15;
  localparam int unsigned TFE_SR_TFLOW_POS = 14;
  localparam int unsigned TFE_SR_SUPER_POS = 13;
  localparam logic [7:0] TFE_VEC_TRACE = 8'h09;
  localparam logic [7:0] TFE_VEC_FORMAT = 8'h0e;
  localparam logic [31:0] TFE_VERSION_OFFSET = 32'h0000_0036;
  localparam logic [3:0] TFE_FMT_SHORT = 4'h0;
  localparam logic [3:0] TFE_FMT_THROWAWAY = 4'h1;
  localparam logic [3:0] TFE_FMT_SIX = 4'h2;
  localparam logic [3:0] TFE_FMT_COPRO = 4'h9;
  localparam logic [3:0] TFE_FMT_SHORT_BUS = 4'ha;
  localparam logic [3:0] TFE_FMT_LONG_BUS = 4'hb;
  localparam logic [7:0] TFE_VERSION_RESET = 8'h00;

  typedef enum logic [1:0] {
    TFE_MODE_OFF,
    TFE_MODE_FLOW,
    TFE_MODE_ALL,
    TFE_MODE_RSVD
  } tfe_mode_t;

  // one instruction as seen by the sequencer
  typedef struct packed {
    logic flow_change;
    logic sr_write;
    logic breakpoint;
    logic stop;
    logic illegal;
    logic forced_exc;
    logic [31:0] next_pc;
  } tfe_instr_t;

  // exception frame request toward the stacking logic
  typedef struct packed {
    logic [7:0] vector;
    logic [3:0] format;
    logic [31:0] stacked_pc;
    logic [15:0] saved_sr;
    logic [31:0] vector_addr;
  } tfe_frame_t;
endpackage : tfe_pkg

// ---- logic/tfe_unit.sv ----
// Purpose: trace exception ordering and format error detection
// Assumes: core sequencer gives instruction begin/complete/fault events
// Notes: one frame request at a time; frame_ack_in retires it
`timescale 1ns/1ps
module tfe_unit #(
  parameter logic [7:0] VERSION = tfe_pkg::TFE_VERSION_RESET
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] sr_in,
  input wire logic instr_begin_in,
  input wire tfe_pkg::tfe_instr_t instr_in,
  input wire logic [31:0] instr_pc_in,
  input wire logic instr_done_in,
  input wire logic instr_fault_in,
  input wire logic irq_pending_in,
  input wire logic [31:0] vbr_in,
  input wire logic [31:0] sp_in,
  input wire logic rte_check_in,
  input wire logic [3:0] rte_format_in,
  input wire logic [7:0] rte_version_in,
  input wire logic restore_in,
  input wire logic [15:0] restore_word_in,
  input wire logic copro_fmt_valid_in,
  input wire logic copro_fmt_bad_in,
  input wire logic forced_done_in,
  input wire logic frame_ack_in,
  output logic [1:0] trace_mode_out,
  output logic sr_write_out,
  output logic [15:0] sr_value_out,
  output logic frame_req_out,
  output tfe_pkg::tfe_frame_t frame_out,
  output logic irq_allow_out,
  output logic [31:0] version_addr_out,
  output logic copro_fmt_req_out,
  output logic [15:0] copro_fmt_word_out,
  output logic stop_enter_out
);
  typedef enum logic [2:0] {
    TFE_IDLE,
    TFE_EXEC,
    TFE_WAIT_FORCED,
    TFE_TRACE,
    TFE_WAIT_COPRO,
    TFE_FMT_ERR
  } tfe_state_t;

  tfe_state_t state_reg;
  tfe_pkg::tfe_mode_t mode_at_begin_reg;
  logic trace_pending_reg;
  logic forced_pending_reg;
  logic stop_traced_reg;
  logic [31:0] next_pc_reg;
  logic [31:0] det_pc_reg;
  logic frame_req_reg;
  tfe_pkg::tfe_frame_t frame_reg;
  logic sr_write_reg;
  logic [15:0] sr_value_reg;
  logic copro_req_reg;
  logic [15:0] copro_word_reg;
  logic stop_enter_reg;
  logic [7:0] vec_sel;
  logic [31:0] vec_addr;
  tfe_pkg::tfe_mode_t live_mode;
  logic wants_trace;
  logic fmt_ok;
  logic version_bad;

  assign live_mode = tfe_pkg::tfe_mode_t'({sr_in[tfe_pkg::TFE_SR_TALL_POS],
                                           sr_in[tfe_pkg::TFE_SR_TFLOW_POS]});

  always_comb begin
    wants_trace = 1'b0;
    case (mode_at_begin_reg)
      tfe_pkg::TFE_MODE_FLOW: wants_trace = instr_in.flow_change | instr_in.sr_write |
                                            instr_in.breakpoint | instr_in.stop;
      tfe_pkg::TFE_MODE_ALL: wants_trace = 1'b1;
      // reserved mode: undefined, treated as no tracing
      default: wants_trace = 1'b0;
    endcase
    if (instr_in.illegal) begin
      wants_trace = 1'b0;
    end
  end

  always_comb begin
    case (rte_format_in)
      tfe_pkg::TFE_FMT_SHORT,
      tfe_pkg::TFE_FMT_THROWAWAY,
      tfe_pkg::TFE_FMT_SIX,
      tfe_pkg::TFE_FMT_COPRO,
      tfe_pkg::TFE_FMT_SHORT_BUS,
      tfe_pkg::TFE_FMT_LONG_BUS: fmt_ok = 1'b1;
      default: fmt_ok = 1'b0;
    endcase
  end

  // version word at sp plus offset
  assign version_addr_out = sp_in + tfe_pkg::TFE_VERSION_OFFSET;
  assign version_bad = (rte_format_in == tfe_pkg::TFE_FMT_LONG_BUS) &&
                       (rte_version_in != VERSION);

  assign vec_sel = (state_reg == TFE_FMT_ERR) ? tfe_pkg::TFE_VEC_FORMAT
                                              : tfe_pkg::TFE_VEC_TRACE;

  tfe_vec_addr u_vec_addr (
    .vbr_in(vbr_in),
    .vector_in(vec_sel),
    .addr_out(vec_addr)
  );

  // main sequencer
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= TFE_IDLE;
    end else begin
      case (state_reg)
        TFE_IDLE: begin
          if (rte_check_in && (!fmt_ok || version_bad)) begin
            state_reg <= TFE_FMT_ERR;
          end else if (restore_in) begin
            state_reg <= TFE_WAIT_COPRO;
          end else if (instr_begin_in) begin
            state_reg <= TFE_EXEC;
          end
        end
        TFE_EXEC: begin
          if (instr_fault_in) begin
            state_reg <= TFE_IDLE;
          end else if (instr_done_in) begin
            // forced exception first
            // pending flag lands on this same edge, so decide from the live verdict
            if (instr_in.forced_exc && wants_trace) begin
              state_reg <= TFE_WAIT_FORCED;
            end else if (wants_trace) begin
              state_reg <= TFE_TRACE;
            end else begin
              state_reg <= TFE_IDLE;
            end
          end
        end
        TFE_WAIT_FORCED: begin
          if (forced_done_in) begin
            state_reg <= TFE_TRACE;
          end
        end
        TFE_TRACE: begin
          if (frame_ack_in) begin
            state_reg <= TFE_IDLE;
          end
        end
        TFE_WAIT_COPRO: begin
          if (copro_fmt_valid_in) begin
            state_reg <= copro_fmt_bad_in ? TFE_FMT_ERR : TFE_IDLE;
          end
        end
        TFE_FMT_ERR: begin
          if (frame_ack_in) begin
            state_reg <= TFE_IDLE;
          end
        end
        default: state_reg <= TFE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_at_begin_reg <= tfe_pkg::TFE_MODE_OFF;
    end else if (state_reg == TFE_IDLE && instr_begin_in) begin
      mode_at_begin_reg <= live_mode;
    end
  end

  // a fault sets no pending trace; the resumed instruction is judged again when it completes
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trace_pending_reg <= 1'b0;
      stop_traced_reg <= 1'b0;
    end else if (state_reg == TFE_EXEC && instr_done_in && !instr_fault_in) begin
      trace_pending_reg <= wants_trace;
      stop_traced_reg <= instr_in.stop && wants_trace;
    end else if (state_reg == TFE_TRACE && frame_ack_in) begin
      trace_pending_reg <= 1'b0;
      stop_traced_reg <= 1'b0;
    end else if (state_reg == TFE_IDLE && instr_begin_in && !trace_pending_reg) begin
      trace_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      forced_pending_reg <= 1'b0;
    end else if (state_reg == TFE_EXEC && instr_done_in && instr_in.forced_exc) begin
      forced_pending_reg <= 1'b1;
    end else if (forced_done_in) begin
      forced_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      next_pc_reg <= 32'h0000_0000;
      det_pc_reg <= 32'h0000_0000;
    end else begin
      if (state_reg == TFE_EXEC && instr_done_in) begin
        next_pc_reg <= instr_in.next_pc;
      end
      if (state_reg == TFE_IDLE && (rte_check_in || restore_in)) begin
        det_pc_reg <= instr_pc_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stop_enter_reg <= 1'b0;
    end else begin
      stop_enter_reg <= state_reg == TFE_EXEC && instr_done_in && !instr_fault_in &&
                        instr_in.stop && !wants_trace;
    end
  end

  // frame build: one-cycle sr update, request held until acknowledged
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      frame_req_reg <= 1'b0;
      frame_reg <= '0;
      sr_write_reg <= 1'b0;
      sr_value_reg <= 16'h0000;
    end else begin
      sr_write_reg <= 1'b0;
      if (frame_req_reg && frame_ack_in) begin
        frame_req_reg <= 1'b0;
      end else if (!frame_req_reg && (state_reg == TFE_TRACE || state_reg == TFE_FMT_ERR)) begin
        frame_req_reg <= 1'b1;
        frame_reg.saved_sr <= sr_in;
        frame_reg.vector_addr <= vec_addr;
        sr_write_reg <= 1'b1;
        sr_value_reg <= sr_in;
        sr_value_reg[tfe_pkg::TFE_SR_SUPER_POS] <= 1'b1;
        sr_value_reg[tfe_pkg::TFE_SR_TALL_POS] <= 1'b0;
        sr_value_reg[tfe_pkg::TFE_SR_TFLOW_POS] <= 1'b0;
        if (state_reg == TFE_TRACE) begin
          frame_reg.vector <= tfe_pkg::TFE_VEC_TRACE;
          frame_reg.format <= tfe_pkg::TFE_FMT_SHORT;
          frame_reg.stacked_pc <= next_pc_reg;
        end else begin
          frame_reg.vector <= tfe_pkg::TFE_VEC_FORMAT;
          frame_reg.format <= tfe_pkg::TFE_FMT_SHORT;
          frame_reg.stacked_pc <= det_pc_reg;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      copro_req_reg <= 1'b0;
      copro_word_reg <= 16'h0000;
    end else if (state_reg == TFE_IDLE && restore_in && !rte_check_in) begin
      copro_req_reg <= 1'b1;
      copro_word_reg <= restore_word_in;
    end else if (copro_fmt_valid_in) begin
      copro_req_reg <= 1'b0;
    end
  end

  assign irq_allow_out = irq_pending_in && !trace_pending_reg && !forced_pending_reg &&
                         (state_reg == TFE_IDLE);

  assign trace_mode_out = live_mode;
  assign sr_write_out = sr_write_reg;
  assign sr_value_out = sr_value_reg;
  assign frame_req_out = frame_req_reg;
  assign frame_out = frame_reg;
  assign copro_fmt_req_out = copro_req_reg;
  assign copro_fmt_word_out = copro_word_reg;
  assign stop_enter_out = stop_enter_reg;
endmodule : tfe_unit

// ---- logic/tfe_vec_addr.sv ----
// Purpose: exception vector fetch address from base and vector number
// Assumes: vector base register supplied by the core
// Notes: purely combinational
`timescale 1ns/1ps
module tfe_vec_addr (
  input wire logic [31:0] vbr_in,
  input wire logic [7:0] vector_in,
  output logic [31:0] addr_out
);
  assign addr_out = vbr_in + {22'h000000, vector_in, 2'b00};
endmodule : tfe_vec_addr

// ---- tb/tb_top.sv ----
// Purpose: random and directed bench for the trace and format error unit
// Assumes: core events driven one instruction at a time
// Notes: vbr_in and sp_in fixed after time zero
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] VER = 8'h5a;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] sr_in = 16'h0, restore_word_in = 16'h0;
  logic instr_begin_in = 0, instr_done_in = 0, instr_fault_in = 0, irq_pending_in = 0;
  logic rte_check_in = 0, restore_in = 0, forced_done_in = 0, frame_ack_in = 0;
  logic copro_fmt_valid_in, copro_fmt_bad_in, sr_write_out, frame_req_out;
  logic irq_allow_out, copro_fmt_req_out, stop_enter_out, stop_seen;
  logic [31:0] instr_pc_in = 32'h0, vbr_in = 32'h0, sp_in = 32'h0, version_addr_out;
  logic [3:0] rte_format_in = 4'h0;
  logic [7:0] rte_version_in = 8'h0;
  logic [1:0] trace_mode_out;
  logic [15:0] sr_value_out, copro_fmt_word_out;
  tfe_pkg::tfe_instr_t instr_in = '0;
  tfe_pkg::tfe_frame_t frame_out;
  int seed, num_errors, cmp_count;
  tfe_unit #(.VERSION(VER)) dut (.*);
  tfe_copro_model cop (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(copro_fmt_req_out),
    .word_in(copro_fmt_word_out), .valid_out(copro_fmt_valid_in), .bad_out(copro_fmt_bad_in));
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (stop_enter_out === 1'b1) stop_seen = 1'b1;
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic traced(input logic [15:0] s, input tfe_pkg::tfe_instr_t i);
    if (i.illegal) return 1'b0;
    if (s[15:14] == 2'b10) return 1'b1;
    if (s[15:14] == 2'b01) return i.flow_change | i.sr_write | i.breakpoint | i.stop;
    return 1'b0;
  endfunction : traced
  task automatic no_frame;
    repeat (8) begin
      @(negedge mclk_in);
      chk("frame_req", 0, frame_req_out);
    end
    @(posedge mclk_in);
  endtask : no_frame
  task automatic take_frame(input logic [7:0] v, input logic [31:0] pc, input logic trc);
    int n;
    n = 0;
    while (frame_req_out !== 1'b1 && n < 30) begin
      @(negedge mclk_in);
      n++;
    end
    if (n == 30) begin
      num_errors++;
      stop_test();
    end
    chk("vector", {24'h0, v}, {24'h0, frame_out.vector});
    chk("format", 0, {28'h0, frame_out.format});
    chk("stacked_pc", pc, frame_out.stacked_pc);
    chk("irq_allow", 0, irq_allow_out);
    if (trc) chk("saved_sr", sr_in, frame_out.saved_sr);
    if (trc) chk("sr_value", {3'b001, sr_in[12:0]}, sr_value_out);
    @(posedge mclk_in);
    frame_ack_in <= 1'b1;
    @(posedge mclk_in);
    frame_ack_in <= 1'b0;
  endtask : take_frame
  task automatic run(input tfe_pkg::tfe_instr_t i, input logic [15:0] s0, s1, input logic f);
    @(posedge mclk_in);
    sr_in <= s0;
    instr_in <= i;
    instr_begin_in <= 1'b1;
    irq_pending_in <= $random(seed);
    @(posedge mclk_in);
    instr_begin_in <= 1'b0;
    sr_in <= s1;
    stop_seen = 1'b0;
    @(posedge mclk_in);
    instr_fault_in <= f;
    instr_done_in <= !f;
    @(posedge mclk_in);
    instr_fault_in <= 1'b0;
    instr_done_in <= 1'b0;
    if (i.forced_exc && !f) begin
      no_frame();
      forced_done_in <= 1'b1;
      @(posedge mclk_in);
      forced_done_in <= 1'b0;
    end
    if (traced(s0, i) && !f) take_frame(8'h09, i.next_pc, 1'b1);
    else no_frame();
    if (i.stop && traced(s0, i)) chk("stop_enter", 0, stop_seen);
    else if (i.stop && !f && !i.illegal) chk("stop_enter", 1, stop_seen);
  endtask : run
  task automatic chk_fmt(input logic r, input logic [3:0] f, input logic [15:0] w);
    logic bad;
    bad = r ? !(f inside {4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hb}) || (f == 4'hb && w[7:0] != VER)
      : w[15:8] != 8'h00 && w[15:8] != 8'h3c;
    @(posedge mclk_in);
    instr_pc_in <= $random(seed) & 32'hffff_fffe;
    rte_check_in <= r;
    restore_in <= !r;
    rte_format_in <= f;
    rte_version_in <= w[7:0];
    restore_word_in <= w;
    @(posedge mclk_in);
    rte_check_in <= 1'b0;
    restore_in <= 1'b0;
    if (bad) take_frame(8'h0e, instr_pc_in, 1'b0);
    else no_frame();
  endtask : chk_fmt
  initial begin
    tfe_pkg::tfe_instr_t i;
    logic [31:0] r;
    seed = 85;
    vbr_in <= $random(seed) & 32'hffff_fc00;
    sp_in <= $random(seed) & 32'hffff_fffc;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    run('{stop: 1'b1, next_pc: 32'h100, default: 1'b0}, 16'h8000, 16'h0000, 1'b0);
    run('{breakpoint: 1'b1, next_pc: 32'h200, default: 1'b0}, 16'h4000, 16'h2000, 1'b0);
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      i = {r[5:0], $random(seed)};
      i.illegal = r[3] & r[4];
      i.forced_exc = r[0] & r[1] & !i.illegal;
      run(i, {r[15:14], 1'b0, r[12:0]}, r[31:16], r[6] & r[7]);
      if (r[6] & r[7]) run(i, {r[15:14], 1'b0, r[12:0]}, r[31:16], 1'b0);
    end
    $display("test instruction trace done");
    for (int k = 0; k < 16; k++) chk_fmt(1'b1, k[3:0], {8'h0, VER});
    chk_fmt(1'b1, 4'hb, {8'h0, VER ^ 8'h01});
    $display("test return format done");
    chk_fmt(1'b0, 4'h0, 16'h0000);
    chk_fmt(1'b0, 4'h0, 16'h3c10);
    chk_fmt(1'b0, 4'h0, 16'h7700);
    chk_fmt(1'b0, 4'h0, $random(seed));
    $display("test state restore done");
    stop_test();
  end
endmodule : tb_top

// ---- tb/tfe_copro_model.sv ----
// Purpose: coprocessor stand-in judging state frame format words
// Assumes: one format request open at a time
// Notes: answers alternate prompt and slow
`timescale 1ns/1ps
module tfe_copro_model #(
  parameter logic [7:0] KNOWN_FMT = 8'h3c
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [15:0] word_in,
  output logic valid_out,
  output logic bad_out
);
  logic [3:0] cnt_reg;
  logic slow_reg;
  logic busy_reg;
  always_ff @(posedge mclk_in) begin
    valid_out <= 1'b0;
    // verdict line is meaningless between answers
    bad_out <= ~bad_out;
    if (rst_in) begin
      busy_reg <= 1'b0;
      slow_reg <= 1'b0;
      bad_out <= 1'b0;
    end else if (req_in && !busy_reg && !valid_out) begin
      busy_reg <= 1'b1;
      cnt_reg <= slow_reg ? 4'h4 : 4'h0;
      slow_reg <= !slow_reg;
    end else if (busy_reg && cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (busy_reg) begin
      valid_out <= 1'b1;
      bad_out <= word_in[15:8] != 8'h00 && word_in[15:8] != KNOWN_FMT;
      busy_reg <= 1'b0;
    end
  end
endmodule : tfe_copro_model

// ---- tb/tfe_unit_assertions.sv ----
// Purpose: checker on the trace and format error unit ports
// Assumes: vbr_in and sp_in held while a frame is up
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module tfe_unit_assertions (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] sr_in,
  input wire logic rte_check_in,
  input wire logic [3:0] rte_format_in,
  input wire logic [31:0] instr_pc_in,
  input wire logic [31:0] vbr_in,
  input wire logic [31:0] sp_in,
  input wire logic frame_ack_in,
  input wire logic copro_fmt_valid_in,
  input wire logic [1:0] trace_mode_out,
  input wire logic sr_write_out,
  input wire logic [15:0] sr_value_out,
  input wire logic frame_req_out,
  input wire tfe_pkg::tfe_frame_t frame_out,
  input wire logic irq_allow_out,
  input wire logic [31:0] version_addr_out,
  input wire logic copro_fmt_req_out,
  input wire logic [15:0] copro_fmt_word_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // only issued while idle, so nothing else is pending
  sequence s_rte_bad;
    rte_check_in && !frame_req_out && !copro_fmt_req_out && rte_format_in == 4'h3;
  endsequence
  sequence s_fmt_frame;
    frame_req_out && frame_out.vector == 8'h0e && frame_out.format == 4'h0;
  endsequence
  AST_MODE: assert property (trace_mode_out == sr_in[15:14])
    else $error("trace mode not taken from status bits");
  AST_VADDR: assert property (frame_req_out |->
    frame_out.vector_addr == vbr_in + {22'h0, frame_out.vector, 2'b00})
    else $error("vector address wrong");
  AST_VER: assert property (version_addr_out == sp_in + 32'h36)
    else $error("version address wrong");
  AST_TRACE_SR: assert property ($rose(frame_req_out) && frame_out.vector == 8'h09 |->
    sr_write_out && sr_value_out[15:13] == 3'b001)
    else $error("trace status update wrong");
  AST_IRQ: assert property (frame_req_out |-> !irq_allow_out)
    else $error("interrupt allowed during frame");
  AST_RTE_BAD: assert property (s_rte_bad |-> ##3 s_fmt_frame ##0
    frame_out.stacked_pc == $past(instr_pc_in, 3))
    else $error("bad format not raised in time");
  AST_HOLD: assert property (frame_req_out && !frame_ack_in |=>
    frame_req_out && $stable(frame_out))
    else $error("frame request dropped");
  AST_COPRO: assert property (copro_fmt_req_out && !copro_fmt_valid_in |=>
    copro_fmt_req_out && $stable(copro_fmt_word_out))
    else $error("coprocessor request dropped");
  AST_SRW: assert property (sr_write_out |=> !sr_write_out)
    else $error("status write longer than one cycle");
endmodule : tfe_unit_assertions
bind tfe_unit tfe_unit_assertions chk_i (.*);
